// ### common/flwsr_pkg.sv
/*
 * Constants for the flash status-poll host: APB register map, field
 * positions, flash bus timing and sequencer state codes.
 * Assumes a 125 MHz clock and a 16-bit status word on the flash data pins.
 */
package flwsr_pkg;
   // APB register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_ADDR   = 8'h04;
   localparam logic [7:0] OFS_WDATA  = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_RDATA  = 8'h10;
   // Control opcodes in CTRL[1:0]
   localparam logic [1:0] OPC_WRITE = 2'h1;
   localparam logic [1:0] OPC_POLL  = 2'h2;
   localparam logic [1:0] OPC_READ  = 2'h3;
   // Status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_RDY  = 3;
   localparam int ST_ETMR = 4;
   localparam int ST_TLIM = 5;
   // Status bit positions on the flash data bus
   localparam int DQ_TOG1 = 6;
   localparam int DQ_TLIM = 5;
   localparam int DQ_ETMR = 3;
   // Reset command datum written after a timing-limit failure
   localparam logic [15:0] RESET_CMD = 16'h00f0;
   // Flash bus timing
   localparam int CLK_NS     = 8;
   localparam int T_PULSE_NS = 120;
   localparam int T_RECOV_NS = 40;
   localparam int SYNC_LAT   = 2;
   localparam int PULSE_CYC  = (T_PULSE_NS + CLK_NS - 1) / CLK_NS + SYNC_LAT;
   localparam int RECOV_CYC  = (T_RECOV_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W      = 5;
   // Sequencer states
   typedef enum logic [1:0] {
      FLWSR_IDLE   = 2'b00,
      FLWSR_STROBE = 2'b01,
      FLWSR_RECOV  = 2'b10
   } flwsr_state_t;
   // Step within an operation
   typedef enum logic [2:0] {
      FLWSR_PH_ONE = 3'b000,
      FLWSR_PH_P1  = 3'b001,
      FLWSR_PH_P2  = 3'b010,
      FLWSR_PH_P3  = 3'b011,
      FLWSR_PH_P4  = 3'b100,
      FLWSR_PH_RST = 3'b101
   } flwsr_phase_t;
endpackage

// ### rtl/flwsr_host.sv
/*
 * Flash status-poll host. Software on APB orders single flash bus write or
 * read cycles, or a full toggle-bit completion poll; results are reported
 * in STATUS and RDATA.
 * Assumes an asynchronous flash on cs/oe/we strobes; data and ready/busy pins
 * come from outside the clock domain and are synchronised here.
 */
module flwsr_host #(
   parameter int ADDR_W = 23,
   parameter int DATA_W = 16
) (
   input  wire logic              i_clk,
   input  wire logic              i_srst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   o_cs_n,
   output logic                   o_oe_n,
   output logic                   o_we_n,
   output logic [ADDR_W-1:0]      o_addr,
   output logic [DATA_W-1:0]      o_dq_out,
   output logic                   o_dq_oe,
   input  wire logic [DATA_W-1:0] i_dq_in,
   input  wire logic              i_ready_busy_n_out
);
   // Status bits must exist on the bus and the address fit the register
   if (DATA_W < 8 || DATA_W > 32 || ADDR_W < 1 || ADDR_W > 32) begin : g_chk
      $error("flwsr_host: unsupported ADDR_W or DATA_W");
   end

   // All state of the block
   typedef struct packed {
      flwsr_pkg::flwsr_state_t st;    // Bus cycle state
      flwsr_pkg::flwsr_phase_t ph;    // Operation step
      logic                    rd;    // Current cycle is a read
      logic [flwsr_pkg::CNT_W-1:0] cnt; // Strobe or recovery count
      logic [DATA_W-1:0] d0;          // First sample of a pair
      logic [DATA_W-1:0] rdat;        // Last read datum
      logic [ADDR_W-1:0] areg;        // Target address register
      logic [DATA_W-1:0] wreg;        // Write datum register
      logic              busy;        // Operation running
      logic              done;        // Operation ended
      logic              fail;        // Poll ended in failure
      logic [DATA_W-1:0] dq_s1;       // Data synchroniser, first stage
      logic [DATA_W-1:0] dq_s2;       // Data synchroniser, second stage
      logic              rb_s1;       // Ready/busy synchroniser, first stage
      logic              rb_s2;       // Ready/busy synchroniser, second stage
      logic              cs_n;        // Chip select pin
      logic              oe_n;        // Output enable pin
      logic              we_n;        // Write strobe pin
      logic [ADDR_W-1:0] addr;        // Address pins
      logic [DATA_W-1:0] dq;          // Data out pins
      logic              dq_oe;       // Data out enable
      logic [31:0]       prd;         // APB read data
      logic              prdy;        // APB ready
      logic              perr;        // APB error
   } flwsr_reg_t;

   flwsr_reg_t s_r;                   // Registered state
   flwsr_reg_t s_nxt;                 // Next state

   // The strobe falls one edge after the count starts, so counting up to
   // PULSE_CYC keeps it low for the full PULSE_CYC cycles
   localparam logic [flwsr_pkg::CNT_W-1:0] PULSE_LAST =
      flwsr_pkg::CNT_W'(flwsr_pkg::PULSE_CYC);
   localparam logic [flwsr_pkg::CNT_W-1:0] RECOV_LAST =
      flwsr_pkg::CNT_W'(flwsr_pkg::RECOV_CYC - 1);

   // APB register read decode
   function automatic logic [32:0] rd_decode(input logic [7:0] a, input flwsr_reg_t s);
      logic [31:0] v;
      logic        ok;
      v  = 32'h0;
      ok = 1'b1;
      unique case (a)
         flwsr_pkg::OFS_CTRL:   v = 32'h0;
         flwsr_pkg::OFS_ADDR:   v[ADDR_W-1:0] = s.areg;
         flwsr_pkg::OFS_WDATA:  v[DATA_W-1:0] = s.wreg;
         flwsr_pkg::OFS_STATUS: begin
            v[flwsr_pkg::ST_BUSY] = s.busy;
            v[flwsr_pkg::ST_DONE] = s.done;
            v[flwsr_pkg::ST_FAIL] = s.fail;
            v[flwsr_pkg::ST_RDY]  = s.rb_s2;
            // erase timer of the last read
            v[flwsr_pkg::ST_ETMR] = s.rdat[flwsr_pkg::DQ_ETMR];
            v[flwsr_pkg::ST_TLIM] = s.rdat[flwsr_pkg::DQ_TLIM];
         end
         flwsr_pkg::OFS_RDATA:  v[DATA_W-1:0] = s.rdat;
         default:               ok = 1'b0;
      endcase
      return {ok, v};
   endfunction

   // Next-state logic
   always_comb begin
      logic [32:0] dec;
      logic        acc;
      logic        wr;
      logic        tog;
      dec   = rd_decode(paddr, s_r);
      acc   = psel & penable;
      wr    = acc & pwrite & s_r.prdy;
      tog   = 1'b0;
      s_nxt = s_r;
      // Synchronisers: only the second stage is read by logic
      s_nxt.dq_s1 = i_dq_in;
      s_nxt.dq_s2 = s_r.dq_s1;
      s_nxt.rb_s1 = i_ready_busy_n_out;
      s_nxt.rb_s2 = s_r.rb_s1;

      // APB slave, one wait state then ready with registered data
      s_nxt.prdy = acc & ~s_r.prdy;
      s_nxt.perr = acc & ~s_r.prdy & ~dec[32];
      if (acc && !s_r.prdy) begin
         s_nxt.prd = dec[31:0];
      end
      // Register writes take effect at the edge that samples pready
      if (wr && dec[32]) begin
         unique case (paddr)
            flwsr_pkg::OFS_ADDR:  s_nxt.areg = pwdata[ADDR_W-1:0];
            flwsr_pkg::OFS_WDATA: s_nxt.wreg = pwdata[DATA_W-1:0];
            flwsr_pkg::OFS_CTRL: begin
               // Orders are ignored while an operation runs
               if (!s_r.busy && pwdata[1:0] != 2'h0) begin
                  s_nxt.busy = 1'b1;
                  s_nxt.done = 1'b0;
                  s_nxt.fail = 1'b0;
                  s_nxt.st   = flwsr_pkg::FLWSR_STROBE;
                  s_nxt.cnt  = '0;
                  s_nxt.rd   = (pwdata[1:0] != flwsr_pkg::OPC_WRITE);
                  s_nxt.ph   = (pwdata[1:0] == flwsr_pkg::OPC_POLL) ?
                               flwsr_pkg::FLWSR_PH_P1 : flwsr_pkg::FLWSR_PH_ONE;
               end
            end
            default: ;
         endcase
      end

      // Flash bus cycle sequencer
      unique case (s_r.st)
         flwsr_pkg::FLWSR_IDLE: begin
            s_nxt.cs_n  = 1'b1;
            s_nxt.oe_n  = 1'b1;
            s_nxt.we_n  = 1'b1;
            s_nxt.dq_oe = 1'b0;
         end
         flwsr_pkg::FLWSR_STROBE: begin
            // status reads use the busy bank address
            s_nxt.addr  = s_r.areg;
            s_nxt.dq    = (s_r.ph == flwsr_pkg::FLWSR_PH_RST) ? DATA_W'(flwsr_pkg::RESET_CMD)
                                                                : s_r.wreg;
            s_nxt.cs_n  = 1'b0;
            s_nxt.oe_n  = ~s_r.rd;
            s_nxt.we_n  = s_r.rd;
            s_nxt.dq_oe = ~s_r.rd;
            s_nxt.cnt   = s_r.cnt + 1'b1;
            if (s_r.cnt == PULSE_LAST) begin
               // Strobes rise; data sampled after synchroniser latency
               s_nxt.st   = flwsr_pkg::FLWSR_RECOV;
               s_nxt.cnt  = '0;
               s_nxt.cs_n = 1'b1;
               s_nxt.oe_n = 1'b1;
               s_nxt.we_n = 1'b1;
               if (s_r.rd) begin
                  s_nxt.rdat = s_r.dq_s2;
               end
            end
         end
         flwsr_pkg::FLWSR_RECOV: begin
            // Data held one recovery period past the write strobe
            s_nxt.cnt = s_r.cnt + 1'b1;
            if (s_r.cnt == RECOV_LAST) begin
               s_nxt.dq_oe = 1'b0;
               s_nxt.cnt   = '0;
               s_nxt.st    = flwsr_pkg::FLWSR_STROBE;
               s_nxt.rd    = 1'b1;
               tog = s_r.rdat[flwsr_pkg::DQ_TOG1] ^ s_r.d0[flwsr_pkg::DQ_TOG1];
               unique case (s_r.ph)
                  flwsr_pkg::FLWSR_PH_P1,
                  flwsr_pkg::FLWSR_PH_P3: begin
                     s_nxt.d0 = s_r.rdat;
                     s_nxt.ph = (s_r.ph == flwsr_pkg::FLWSR_PH_P1) ?
                                flwsr_pkg::FLWSR_PH_P2 : flwsr_pkg::FLWSR_PH_P4;
                  end
                  flwsr_pkg::FLWSR_PH_P2: begin
                     if (!tog) begin
                        s_nxt.st   = flwsr_pkg::FLWSR_IDLE;
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                     end else if (s_r.rdat[flwsr_pkg::DQ_TLIM]) begin
                        s_nxt.d0 = s_r.rdat;
                        s_nxt.ph = flwsr_pkg::FLWSR_PH_P4;
                     end else begin
                        s_nxt.ph = flwsr_pkg::FLWSR_PH_P1;
                     end
                  end
                  flwsr_pkg::FLWSR_PH_P4: begin
                     if (!tog) begin
                        s_nxt.st   = flwsr_pkg::FLWSR_IDLE;
                        s_nxt.busy = 1'b0;
                        s_nxt.done = 1'b1;
                     end else begin
                        s_nxt.fail = 1'b1;
                        s_nxt.rd   = 1'b0;
                        s_nxt.ph   = flwsr_pkg::FLWSR_PH_RST;
                     end
                  end
                  default: begin
                     // Single cycle or reset write finished
                     s_nxt.st   = flwsr_pkg::FLWSR_IDLE;
                     s_nxt.busy = 1'b0;
                     s_nxt.done = 1'b1;
                  end
               endcase
            end
         end
         default: s_nxt.st = flwsr_pkg::FLWSR_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_r      <= '0;
         s_r.cs_n <= 1'b1;
         s_r.oe_n <= 1'b1;
         s_r.we_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign prdata   = s_r.prd;
   assign pready   = s_r.prdy;
   assign pslverr  = s_r.perr;
   assign o_cs_n   = s_r.cs_n;
   assign o_oe_n   = s_r.oe_n;
   assign o_we_n   = s_r.we_n;
   assign o_addr   = s_r.addr;
   assign o_dq_out = s_r.dq;
   assign o_dq_oe  = s_r.dq_oe;
endmodule

// ### test/flwsr_host_asserts.sv
/* Checker for the flash status-poll host: APB handshake and flash strobes.
   Assumes it is bound to the host top and sees only its ports. */
module flwsr_host_asserts #(
   parameter int ADDR_W = 23
) (
   input wire logic              i_clk,
   input wire logic              i_srst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              o_cs_n,
   input wire logic              o_oe_n,
   input wire logic              o_we_n,
   input wire logic [ADDR_W-1:0] o_addr,
   input wire logic              o_dq_oe
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   logic [7:0] low_cnt_r;  // Cycles the select has been low
   // Counted here, since a 17-cycle repetition is too long to unroll
   always_ff @(posedge i_clk) begin
      low_cnt_r <= o_cs_n ? 8'h00 : low_cnt_r + 8'h01;
   end
   sequence s_recov; o_cs_n [*5]; endsequence
   property p_pulse; pready |=> !pready; endproperty
   property p_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_excl; o_oe_n || o_we_n; endproperty
   property p_sel; !o_oe_n || !o_we_n |-> !o_cs_n; endproperty
   property p_bus; !o_oe_n |-> !o_dq_oe; endproperty
   property p_drive; !o_we_n |-> o_dq_oe; endproperty
   property p_len; $rose(o_cs_n) |-> low_cnt_r == 8'(flwsr_pkg::PULSE_CYC); endproperty
   property p_recov; $rose(o_cs_n) |-> s_recov; endproperty
   property p_addr; !o_cs_n && !$past(o_cs_n) |-> $stable(o_addr); endproperty
   a_pulse: assert property (p_pulse) else $error("pready held too long");
   a_wait: assert property (p_wait) else $error("pready not after one wait state");
   a_err: assert property (p_err) else $error("pslverr without pready");
   a_excl: assert property (p_excl) else $error("read and write strobes together");
   a_sel: assert property (p_sel) else $error("strobe without select");
   a_bus: assert property (p_bus) else $error("host drives data in a read");
   a_drive: assert property (p_drive) else $error("write strobe without data drive");
   a_len: assert property (p_len) else $error("strobe length wrong");
   a_recov: assert property (p_recov) else $error("recovery too short");
   a_addr: assert property (p_addr) else $error("address moved in a cycle");
endmodule

// ### test/flwsr_flash_model.sv
/* Behavioural flash: status bits while working, array data otherwise.
   Assumes a host on cs/oe/we strobes; i_mode picks program, erase, fault or
   a read of an erase-suspended sector. */
module flwsr_flash_model #(
   parameter logic [15:0] ARRAY    = 16'h1234,
   parameter int          OP_READS = 5
) (
   input  wire logic        i_cs_n,
   input  wire logic        i_oe_n,
   input  wire logic        i_we_n,
   input  wire logic [1:0]  i_mode,
   input  wire logic [15:0] i_dq,
   output logic [15:0]      o_dq,
   output logic             o_rb_n,
   output logic [15:0]      o_last_cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        busy, tog, tlim, ers, sus, armed;  // Working, toggle, limit, erase, suspended
   int          left;                         // Reads until the operation ends
   logic [15:0] word;                         // Status or array word
   initial begin
      busy = 1'b0;
      armed = 1'b0;
      o_last_cmd = 16'h0000;
   end
   // Ignore the reset-time rise of the strobe from unknown
   always @(negedge i_we_n) armed = 1'b1;
   // status from strobe rise; reset datum ends work
   always @(posedge i_we_n) begin
      if (armed) begin
         o_last_cmd = i_dq;
         busy = (i_dq != 16'h00f0);
         tog = 1'b0;
         tlim = 1'b0;
         left = OP_READS;
      end
   end
   // invert per read; a limit fault never finishes
   // status for a few reads, then array data again
   always @(posedge i_oe_n) begin
      if (busy) begin
         tog = ~tog;
         if (i_mode == 2'h2) begin
            tlim = 1'b1;
         end else begin
            left = left - 1;
            if (left == 0) busy = 1'b0;
         end
      end
   end
   // suspended sector: poll bit 1, toggle one steady, toggle two toggles
   // array data whenever no operation is shown
   always_comb begin
      ers  = (i_mode == 2'h1);
      sus  = (i_mode == 2'h3);
      word = busy ? {8'h00, sus | (~ers & ~ARRAY[7]), tog & ~sus, tlim, 1'b0, ers,
                     (ers | sus) & tog, ARRAY[1:0]}
                  : ARRAY;
   end
   // drive when read; otherwise inverted so a stale sample shows
   assign o_dq = (!i_cs_n && !i_oe_n) ? word : ~word;
   // open drain low while working, released in suspend; pull-up gives high
   assign o_rb_n = ~busy | sus;
endmodule

// ### test/tb_top.sv
/* Bench for the flash status-poll host: APB orders, toggle polls, a fault.
   Assumes the host, its checker and the flash model in this folder. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          ADDR_W = 23;
   localparam logic [15:0] ARRAY  = 16'h1234;
   logic i_clk, i_srst, psel, penable, pwrite, pready, pslverr, e;
   logic o_cs_n, o_oe_n, o_we_n, o_dq_oe, rb_n;
   logic [7:0]        paddr;
   logic [31:0]       pwdata, prdata, q;
   logic [ADDR_W-1:0] o_addr;
   logic [15:0]       o_dq_out, dev_dq, dq_bus, last_cmd;
   logic [1:0]        mode;
   int                mismatches, comparisons, cycles;
   // Shared data wire: host wins while its enable is high
   assign dq_bus = o_dq_oe ? o_dq_out : dev_dq;
   flwsr_host #(.ADDR_W(ADDR_W), .DATA_W(16)) i_dut (.i_clk(i_clk), .i_srst(i_srst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_cs_n(o_cs_n),
      .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr), .o_dq_out(o_dq_out),
      .o_dq_oe(o_dq_oe), .i_dq_in(dq_bus), .i_ready_busy_n_out(rb_n));
   flwsr_flash_model #(.ARRAY(ARRAY), .OP_READS(5)) i_flash (.i_cs_n(o_cs_n),
      .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_mode(mode), .i_dq(dq_bus), .o_dq(dev_dq),
      .o_rb_n(rb_n), .o_last_cmd(last_cmd));
   task automatic give_verdict;
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One APB transfer; holds everything until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Poll STATUS until busy clears; the global timeout bounds it
   task automatic idle;
      do apb(1'b0, flwsr_pkg::OFS_STATUS, 32'h0); while (q[0] !== 1'b0);
   endtask
   task automatic t_regs;
      apb(1'b0, flwsr_pkg::OFS_STATUS, 32'h0);
      chk(q, 32'h8);
      apb(1'b1, flwsr_pkg::OFS_ADDR, 32'hffffffff);
      apb(1'b0, flwsr_pkg::OFS_ADDR, 32'h0);
      chk(q, 32'h007fffff);
      apb(1'b0, 8'h14, 32'h0);
      chk({q[31:1], e}, 32'h1);
   endtask
   // Command write, one status read, then a toggle poll; mode 2 ends in a
   // limit fault, mode 3 reads an erase-suspended sector
   task automatic t_op(input logic [1:0] m);
      mode <= m;
      apb(1'b1, flwsr_pkg::OFS_ADDR, 32'h555);
      apb(1'b1, flwsr_pkg::OFS_WDATA, 32'h00a0);
      apb(1'b1, flwsr_pkg::OFS_CTRL, 32'(flwsr_pkg::OPC_WRITE));
      idle();
      chk(q & 32'h8, (m == 2'h3) ? 32'h8 : 32'h0);
      apb(1'b1, flwsr_pkg::OFS_CTRL, 32'(flwsr_pkg::OPC_READ));
      idle();
      chk(q & 32'h10, (m == 2'h1) ? 32'h10 : 32'h0);
      apb(1'b1, flwsr_pkg::OFS_CTRL, 32'(flwsr_pkg::OPC_POLL));
      idle();
      chk(q, (m == 2'h2) ? 32'h2e : ((m == 2'h3) ? 32'h0a : 32'h2a));
      apb(1'b0, flwsr_pkg::OFS_RDATA, 32'h0);
      if (m != 2'h2) chk(q, (m == 2'h3) ? 32'h80 : 32'(ARRAY));
      chk(32'(last_cmd), (m == 2'h2) ? 32'h00f0 : 32'h00a0);
      chk(32'(rb_n), 32'h1);
      chk(32'(o_addr), 32'h555);
   endtask
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // Hang guard, far above the several hundred cycles the run needs
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 30000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      {i_srst, psel, penable, pwrite, paddr, pwdata, mode} = {4'h8, 8'h00, 32'h0, 2'h0};
      repeat (4) @(posedge i_clk);
      i_srst <= 1'b0;
      t_regs();
      t_op(2'h0);
      t_op(2'h1);
      t_op(2'h2);
      t_op(2'h3);
      give_verdict();
   end
endmodule
bind flwsr_host flwsr_host_asserts #(.ADDR_W(ADDR_W)) u_chk (.i_clk(i_clk), .i_srst(i_srst),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .o_cs_n(o_cs_n),
   .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr), .o_dq_oe(o_dq_oe));
